// >>> hdl/acl_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface acl_cmp_if
	import acl_pkg::*;
();
	logic [RES_W-1:0] rawResult;
	logic [RES_W-1:0] compareValue;
	logic             tenBit;
	logic             greaterSel;
	logic [RES_W-1:0] diff;
	logic             diffSign;
	logic             condMet;

	modport requester (
		output rawResult,
		output compareValue,
		output tenBit,
		output greaterSel,
		input  diff,
		input  diffSign,
		input  condMet
	);

	modport unit (
		input  rawResult,
		input  compareValue,
		input  tenBit,
		input  greaterSel,
		output diff,
		output diffSign,
		output condMet
	);
endinterface : acl_cmp_if

`default_nettype wire

// >>> hdl/acl_compare.sv
`timescale 1ns/1ps
`default_nettype none

module acl_compare
	import acl_pkg::*;
(
	acl_cmp_if.unit cmp
);
	logic [RES_W:0] termA;
	logic [RES_W:0] termB;
	logic [RES_W:0] wide;

	always_comb begin
		// zero sign bit added so both terms are positive signed values
		if (cmp.tenBit) begin
			termA = {1'b0, cmp.rawResult};
			termB = {1'b0, cmp.compareValue};
		end else begin
			termA = {{(HIGH_W + 1){1'b0}}, cmp.rawResult[BYTE_W-1:0]};
			termB = {{(HIGH_W + 1){1'b0}}, cmp.compareValue[BYTE_W-1:0]};
		end
		wide = termA - termB;
		cmp.diffSign = wide[RES_W];
		// sign bit dropped; in 8-bit operation only the low byte is kept
		if (cmp.tenBit) begin
			cmp.diff = wide[RES_W-1:0];
		end else begin
			cmp.diff = {{HIGH_W{1'b0}}, wide[BYTE_W-1:0]};
		end
		// upper limit: result >= compare; lower limit: result < compare
		cmp.condMet = cmp.greaterSel ? ~wide[RES_W] : wide[RES_W];
	end
endmodule : acl_compare

`default_nettype wire

// >>> hdl/acl_pkg.sv
package acl_pkg;

	// converter data width and conversion counter width
	localparam int RES_W = 10;
	localparam int CNT_W = 6;

	// conversion length in conversion-clock ticks (short sample)
	localparam logic [CNT_W-1:0] CONV_ADCK_8  = 6'h14;
	localparam logic [CNT_W-1:0] CONV_ADCK_10 = 6'h17;
	localparam logic [CNT_W-1:0] CNT_STEP     = 6'h01;

	// conversion clock source select codes
	localparam logic [1:0] CLKSEL_BUS      = 2'h0;
	localparam logic [1:0] CLKSEL_BUS_DIV2 = 2'h1;
	localparam logic [1:0] CLKSEL_ALT      = 2'h2;
	localparam logic [1:0] CLKSEL_ASYNC    = 2'h3;

	// positions inside the pin synchroniser vectors
	localparam int SYNC_HW    = 0;
	localparam int SYNC_ASYNC = 1;
	localparam int SYNC_WAIT  = 2;
	localparam int SYNC_STOP3 = 3;
	localparam int SYNC_STOP2 = 4;
	localparam int SYNC_W     = 5;

	// byte split of the result
	localparam int BYTE_W = 8;
	localparam int HIGH_W = RES_W - BYTE_W;

	typedef enum logic {
		ACL_IDLE,
		ACL_CONVERT
	} acl_state_t;

	typedef struct packed {
		acl_state_t          state;
		logic [CNT_W-1:0]    cnt;
		logic                conversion_complete_flag;
		logic [RES_W-1:0]    result;
		logic                sign;
		logic                blocking;
		logic [SYNC_W-1:0]   sync1;
		logic [SYNC_W-1:0]   sync2;
		logic                hwPrev;
		logic                asyncPrev;
		logic                div2;
	} acl_regs_t;

	localparam acl_regs_t ACL_REGS_RST = '0;

endpackage : acl_pkg

// >>> hdl/adc_compare_lowpower_control.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - limit compare runs only with compare enable set; else normal transfer
// - difference is conversion result minus the compare value
// - upper limit: flag set when result is at least the compare value
// - lower limit: flag set when result is below the compare value
// - interrupt raised while flag set and completion interrupt enabled
// - difference is one bit wider; stored with sign bit dropped
// - compare false: flag stays clear, result registers untouched
// - ten-bit: eleven-bit difference, lower ten bits stored
// - implied sign zero for upper limit, one for lower limit
// - compare keeps working in wait and stop3, interrupt wakes the processor
// - conversion running at wait entry runs to completion
// - in wait, hardware trigger and continuous mode start conversions
// - in wait, bus, bus half or async clock may pace conversions
// - completion in wait sets flag and raises enabled wake interrupt
// - stop3 without async clock aborts to idle, results kept
// - stop3 with async clock keeps converting and accepting starts
// - completion in stop3 sets flag and raises enabled wake interrupt
// - stop2 disables converter; all but the pin synchronisers return to reset values
// - single conversion with false compare ignores blocking and stops
// - writes to control two, config or compare values abort conversion
module adc_compare_lowpower_control
	import acl_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,

	// configuration levels
	input  wire logic               limitCompareEnable,
	input  wire logic               compareGreaterSelect,
	input  wire logic [HIGH_W-1:0]  compareValueHigh,
	input  wire logic [BYTE_W-1:0]  compareValueLow,
	input  wire logic               completionIrqEnable,
	input  wire logic               continuousConvertSelect,
	input  wire logic               hwTriggerEnable,
	input  wire logic               tenBitMode,
	input  wire logic [1:0]         clockSelect,

	// register access strobes, one cycle each
	input  wire logic               swStart,
	input  wire logic               configWrite,
	input  wire logic               resultHighRead,
	input  wire logic               resultLowRead,

	// same-domain clock enable and analog sample
	input  wire logic               alternateClockTick,
	input  wire logic [RES_W-1:0]   analogSample,

	// pins from other domains
	input  wire logic               hwTrigger,
	input  wire logic               asyncConversionClock,
	input  wire logic               waitMode,
	input  wire logic               stop3Mode,
	input  wire logic               stop2Mode,

	// status and results
	output logic                    conversionCompleteFlag,
	output logic                    conversionActive,
	output logic [BYTE_W-1:0]       resultHighByte,
	output logic [BYTE_W-1:0]       resultLowByte,
	output logic                    resultSign,
	output logic                    convIrq,
	output logic                    cpuWakeRequest
);
	acl_regs_t q;
	acl_regs_t d;

	acl_cmp_if cmpBus ();

	acl_compare compareUnit (
		.cmp (cmpBus.unit)
	);

	logic [SYNC_W-1:0] pinsIn;
	logic              hwEdge;
	logic              adckTick;
	logic              asyncSelected;
	logic              stop3Abort;
	logic [CNT_W-1:0]  convLen;
	logic [CNT_W-1:0]  cntNext;
	logic              startReq;
	logic              finish;
	logic              compareFalse;
	logic              cocoSet;
	logic              cocoClr;

	assign pinsIn = {stop2Mode, stop3Mode, waitMode, asyncConversionClock, hwTrigger};

	assign cmpBus.rawResult    = analogSample;
	assign cmpBus.compareValue = {compareValueHigh, compareValueLow};
	assign cmpBus.tenBit       = tenBitMode;
	assign cmpBus.greaterSel   = compareGreaterSelect;

	always_comb begin
		d = q;

		// two-stage synchronisers; only the second stage is read below
		d.sync1     = pinsIn;
		d.sync2     = q.sync1;
		d.hwPrev    = q.sync2[SYNC_HW];
		d.asyncPrev = q.sync2[SYNC_ASYNC];
		d.div2      = ~q.div2;

		hwEdge = hwTriggerEnable & q.sync2[SYNC_HW] & ~q.hwPrev;

		// conversion clock enable; the slow async clock is caught as a rising edge
		asyncSelected = (clockSelect == CLKSEL_ASYNC);
		case (clockSelect)
			CLKSEL_BUS: begin
				adckTick = 1'b1;
			end
			CLKSEL_BUS_DIV2: begin
				adckTick = q.div2;
			end
			CLKSEL_ALT: begin
				adckTick = alternateClockTick;
			end
			CLKSEL_ASYNC: begin
				adckTick = q.sync2[SYNC_ASYNC] & ~q.asyncPrev;
			end
			default: begin
				adckTick = 1'b0;
			end
		endcase

		// wait mode changes nothing here, so running conversions finish and
		// hardware or continuous starts are still taken
		stop3Abort = q.sync2[SYNC_STOP3] & ~asyncSelected;

		convLen  = tenBitMode ? CONV_ADCK_10 : CONV_ADCK_8;
		cntNext  = q.cnt + CNT_STEP;
		startReq = swStart | hwEdge;
		finish   = (q.state == ACL_CONVERT) && adckTick && (cntNext == convLen);

		compareFalse = limitCompareEnable & ~cmpBus.condMet;
		cocoSet      = 1'b0;
		cocoClr      = swStart | resultLowRead;

		// a read of the high byte in ten-bit mode holds off transfers until
		// the low byte is read
		if (resultHighRead && tenBitMode) begin
			d.blocking = 1'b1;
		end else if (resultLowRead) begin
			d.blocking = 1'b0;
		end

		case (q.state)
			ACL_IDLE: begin
				if (startReq) begin
					d.state = ACL_CONVERT;
					d.cnt   = '0;
				end
			end
			ACL_CONVERT: begin
				// an abort in the finishing cycle wins, so nothing is transferred
				if (finish && !configWrite && !stop3Abort) begin
					d.cnt = '0;
					if (compareFalse) begin
						// no flag, no transfer, blocking irrelevant
						d.state = continuousConvertSelect ? ACL_CONVERT : ACL_IDLE;
					end else if (q.blocking) begin
						// result lost, another conversion regardless of mode
						d.state = ACL_CONVERT;
					end else begin
						if (limitCompareEnable) begin
							d.result = cmpBus.diff;
							d.sign   = cmpBus.diffSign;
						end else begin
							// eight-bit operation keeps only the low byte of the sample
							d.result = tenBitMode ? analogSample
								: {{HIGH_W{1'b0}}, analogSample[BYTE_W-1:0]};
							d.sign   = 1'b0;
						end
						cocoSet = 1'b1;
						d.state = continuousConvertSelect ? ACL_CONVERT : ACL_IDLE;
					end
				end else if (adckTick) begin
					d.cnt = cntNext;
				end
				// hardware edges while busy are ignored
				if (swStart) begin
					d.state = ACL_CONVERT;
					d.cnt   = '0;
				end
			end
			default: begin
				d.state = ACL_IDLE;
				d.cnt   = '0;
			end
		endcase

		// set wins over clear
		d.conversion_complete_flag = cocoSet | (q.conversion_complete_flag & ~cocoClr);

		// a mode change makes the current conversion invalid; results untouched
		if (configWrite) begin
			d.state = ACL_IDLE;
			d.cnt   = '0;
		end

		// stop3 on a stopped clock: back to idle; a new trigger is needed after
		if (stop3Abort) begin
			d.state = ACL_IDLE;
			d.cnt   = '0;
		end

		// stop2 powers the converter down; all state returns to reset values
		// while the pin synchronisers keep running
		if (q.sync2[SYNC_STOP2]) begin
			d           = ACL_REGS_RST;
			d.sync1     = pinsIn;
			d.sync2     = q.sync1;
			d.hwPrev    = q.sync2[SYNC_HW];
			d.asyncPrev = q.sync2[SYNC_ASYNC];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= ACL_REGS_RST;
		end else begin
			q <= d;
		end
	end

	assign conversionCompleteFlag = q.conversion_complete_flag;
	assign conversionActive       = (q.state == ACL_CONVERT);
	assign resultHighByte         = {{(BYTE_W - HIGH_W){1'b0}}, q.result[RES_W-1:BYTE_W]};
	assign resultLowByte          = q.result[BYTE_W-1:0];
	assign resultSign             = q.sign;
	// level interrupt follows the flag while enabled
	assign convIrq                = q.conversion_complete_flag & completionIrqEnable;
	assign cpuWakeRequest         = convIrq & (q.sync2[SYNC_WAIT] | q.sync2[SYNC_STOP3]);

endmodule : adc_compare_lowpower_control

`default_nettype wire

// >>> sim/acl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acl_chk
	import acl_pkg::*;
(
	// watched top-level ports
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              limitCompareEnable,
	input wire logic              compareGreaterSelect,
	input wire logic              completionIrqEnable,
	input wire logic              tenBitMode,
	input wire logic [1:0]        clockSelect,
	input wire logic              configWrite,
	input wire logic              waitMode,
	input wire logic              stop3Mode,
	input wire logic              stop2Mode,
	input wire logic              conversionCompleteFlag,
	input wire logic              conversionActive,
	input wire logic [BYTE_W-1:0] resultHighByte,
	input wire logic [BYTE_W-1:0] resultLowByte,
	input wire logic              resultSign,
	input wire logic              convIrq,
	input wire logic              cpuWakeRequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [15:0] res = {resultHighByte, resultLowByte};
	AST_IRQ: assert property (convIrq == (conversionCompleteFlag && completionIrqEnable))
		else $error("irq not following flag");
	AST_WAKE: assert property (cpuWakeRequest |-> convIrq)
		else $error("wake without irq");
	AST_WAIT: assert property (waitMode [*3] ##0 convIrq |-> cpuWakeRequest)
		else $error("no wake in wait");
	AST_SIGN: assert property ($rose(conversionCompleteFlag) && limitCompareEnable |-> resultSign != compareGreaterSelect)
		else $error("bad implied sign");
	AST_BYTE: assert property ($rose(conversionCompleteFlag) && !tenBitMode |-> resultHighByte == 8'h00)
		else $error("high byte set in 8-bit");
	// stop2 pin lag is the sync depth, so only pin-low cycles are judged
	AST_KEEP: assert property ($changed(res) && !stop2Mode |-> $past(conversionActive) && conversionCompleteFlag)
		else $error("result changed without flag");
	AST_CFG: assert property (configWrite |=> !conversionActive && $stable(res))
		else $error("config write did not abort");
	AST_STOP3: assert property (stop3Mode [*4] ##0 (clockSelect != CLKSEL_ASYNC) |-> !conversionActive)
		else $error("stop3 did not abort");
	AST_STOP2: assert property (stop2Mode [*4] |-> !conversionActive && !conversionCompleteFlag && res == 16'h0000)
		else $error("stop2 not reset");
	C_WAKE: cover property ($rose(cpuWakeRequest));
	C_LOW: cover property ($rose(conversionCompleteFlag) && limitCompareEnable && !compareGreaterSelect);
	C_ABORT: cover property (configWrite && conversionActive);
endmodule : acl_chk
bind adc_compare_lowpower_control acl_chk i_chk (.clk, .rst_n, .limitCompareEnable,
	.compareGreaterSelect, .completionIrqEnable, .tenBitMode, .clockSelect, .configWrite,
	.waitMode, .stop3Mode, .stop2Mode, .conversionCompleteFlag, .conversionActive,
	.resultHighByte, .resultLowByte, .resultSign, .convIrq, .cpuWakeRequest);
`default_nettype wire

// >>> sim/test_adc_compare_lowpower_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	n_tests++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("[FAIL] %s exp %h got %h", nm, e, g); \
	end
module test_adc_compare_lowpower_control
	import acl_pkg::*;
;
	logic             clk = 1'b0;
	logic             rst_n, en, gt, irqEn, hwEn, ten, sw, cfgWr, hiRd, loRd;
	logic             hwTrig, waitM, stop3M, stop2M, cont;
	logic             altTick = 1'b0;
	logic             asyncClk = 1'b0;
	logic [1:0]       cs;
	logic [RES_W-1:0] sample, cv;
	logic             flag, act, sign, irq, wake;
	logic             seen = 1'b0;
	logic [7:0]       resHi, resLo;
	logic [16:0]      q[$];
	logic [16:0]      last = 17'h0_0000;
	logic [16:0]      got;
	int               num_errors = 0;
	int               n_tests = 0;
	int               i;
	always #10 clk = ~clk;
	// odd half period keeps the pin unrelated in phase to clk
	always #37 asyncClk = ~asyncClk;
	always @(posedge clk) altTick <= 1'($urandom);
	adc_compare_lowpower_control i_dut (.clk, .rst_n, .limitCompareEnable(en),
		.compareGreaterSelect(gt), .compareValueHigh(cv[9:8]), .compareValueLow(cv[7:0]),
		.completionIrqEnable(irqEn), .continuousConvertSelect(cont), .hwTriggerEnable(hwEn),
		.tenBitMode(ten), .clockSelect(cs), .swStart(sw), .configWrite(cfgWr),
		.resultHighRead(hiRd), .resultLowRead(loRd), .alternateClockTick(altTick),
		.analogSample(sample), .hwTrigger(hwTrig), .asyncConversionClock(asyncClk),
		.waitMode(waitM), .stop3Mode(stop3M), .stop2Mode(stop2M),
		.conversionCompleteFlag(flag), .conversionActive(act), .resultHighByte(resHi),
		.resultLowByte(resLo), .resultSign(sign), .convIrq(irq), .cpuWakeRequest(wake));
	always @(negedge clk) begin
		if (flag && !seen) begin
			got = q.size() ? q.pop_front() : 'x;
			`CHK("result", got, {sign, resHi, resLo})
		end
		seen = flag;
	end
	task automatic finish_test;
		if (num_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	task automatic run(input logic st3, input logic hb);
		logic [10:0] d;
		logic        ok;
		logic [16:0] e;
		int          n;
		@(posedge clk);
		d = ten ? {1'b0, sample} - {1'b0, cv} : {3'b0, sample[7:0]} - {3'b0, cv[7:0]};
		ok = !en || (gt ? !d[10] : d[10]);
		e = !en ? {1'b0, ten ? {6'h00, sample} : {8'h00, sample[7:0]}}
			: {d[10], ten ? {6'h00, d[9:0]} : {8'h00, d[7:0]}};
		if (ok) q.push_back(e);
		else e = last;
		// a ten-bit high read alone sets blocking, which a false single compare must ignore
		hiRd <= hb && !ok;
		@(posedge clk) {hiRd, sw} <= 2'b01;
		@(posedge clk) {sw, stop3M} <= {1'b0, st3};
		for (n = 0; n < 400; n++) begin
			@(posedge clk);
			#1;
			if (!act) break;
		end
		`CHK("active", 1'b0, act)
		`CHK("flag", ok, flag)
		`CHK("irq", ok & irqEn, irq)
		`CHK("wake", ok & irqEn & (waitM | st3), wake)
		`CHK("kept", e, {sign, resHi, resLo})
		last = e;
		@(posedge clk) {loRd, waitM, stop3M} <= 3'b100;
		@(posedge clk) loRd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : run
	initial begin
		{rst_n, en, gt, irqEn, hwEn, ten, sw, cfgWr, hiRd, loRd} = '0;
		{hwTrig, waitM, stop3M, stop2M, cont, cs, sample, cv} = '0;
		void'($urandom(32'h1a82));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk) {ten, en, gt, sample, cv} <= {3'b110, 10'h080, 10'h200};
		run(1'b0, 1'b0);
		for (i = 0; i < 2; i++) begin
			@(posedge clk) {ten, en, gt, sample, cv} <= {2'b11, i[0], 10'h155, 10'h155};
			run(1'b0, 1'b1);
		end
		for (i = 0; i < 24; i++) begin
			@(posedge clk) {ten, en, gt, irqEn} <= 4'($urandom);
			cs <= 2'(i);
			sample <= 10'($urandom);
			cv <= 10'($urandom);
			waitM <= i[2];
			run(i[1:0] == 2'h3 && i[3], i[4]);
		end
		{cs, en} <= {CLKSEL_BUS, 1'b0};
		for (i = 0; i < 2; i++) begin
			@(posedge clk) sw <= 1'b1;
			@(posedge clk) sw <= 1'b0;
			repeat (4) @(posedge clk);
			{cfgWr, stop3M} <= {!i[0], i[0]};
			@(posedge clk) cfgWr <= 1'b0;
			repeat (30) @(posedge clk);
			stop3M <= 1'b0;
			repeat (30) @(posedge clk);
			#1;
			`CHK("abort", {2'b00, last}, {act, flag, sign, resHi, resLo})
		end
		// continuous: a false compare keeps converting, a true one transfers
		@(posedge clk) {cont, ten, en, gt, sample, cv} <= {4'hf, 10'h100, 10'h3ff};
		@(posedge clk) sw <= 1'b1;
		@(posedge clk) sw <= 1'b0;
		repeat (60) @(posedge clk);
		#1;
		`CHK("contfalse", 2'b10, {act, flag})
		q.push_back(17'h0_0000);
		@(posedge clk) sample <= 10'h3ff;
		repeat (30) @(posedge clk);
		#1;
		`CHK("conttrue", 2'b11, {act, flag})
		@(posedge clk) {cfgWr, loRd, cont, en} <= 4'hc;
		@(posedge clk) {cfgWr, loRd} <= 2'b00;
		#1;
		`CHK("contstop", 2'b00, {act, flag})
		@(posedge clk) {hwEn, waitM, irqEn, ten, hwTrig} <= 5'h1f;
		q.push_back({7'h00, sample});
		repeat (3) @(posedge clk);
		hwTrig <= 1'b0;
		repeat (40) @(posedge clk);
		#1;
		`CHK("hwstart", 3'b111, {flag, irq, wake})
		@(posedge clk) stop2M <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		`CHK("stop2", 19'h0_0000, {act, flag, sign, resHi, resLo})
		@(posedge clk) stop2M <= 1'b0;
		// stop2 leaves the result at its reset value
		last = '0;
		repeat (4) @(posedge clk);
		{cfgWr, en, gt, ten, sample, cv} <= {4'h7, 10'h3ff, 10'h001};
		@(posedge clk) cfgWr <= 1'b0;
		run(1'b0, 1'b0);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test();
	end
endmodule : test_adc_compare_lowpower_control
`default_nettype wire
